/* logic/ccs_clock_switch.sv */
// Purpose: clock source request, switch sequencing and oscillator status
// Assumes: zero-wait AHB-Lite slave; oscillator ready flags synchronous to hclk
// Notes: power-on request value is a strap caught once after reset release
`timescale 1ns/10ps
module ccs_clock_switch (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [7:0]         haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               switch_allow_config,
   input  wire ccs_pkg::ccs_sel_s  power_on_sel,
   input  wire ccs_pkg::ccs_rdy_s  osc_ready,
   output ccs_pkg::ccs_sel_s       current_sel,
   output ccs_pkg::ccs_sel_s       requested_sel,
   output logic [9:0]              divide_ratio,
   output logic                    switch_irq_flag,
   output logic                    secondary_high_power,
   output logic                    secondary_bypass_en,
   output logic                    secondary_xtal_en
);
   import ccs_pkg::*;

   ccs_sel_s   req_reg;
   ccs_sel_s   cur_reg;
   ccs_state_e state_reg;
   logic       loaded_reg;
   logic       hold_reg;
   logic       pwr_reg;
   logic       byp_reg;
   logic       irq_reg;
   logic [9:0] ratio_reg;
   logic       dp_wr_reg;
   logic [7:0] dp_addr_reg;
   logic [31:0] rdata_reg;

   logic       addr_phase;
   logic       wr_req;
   logic       wr_ctrl;
   logic       new_rdy;
   logic       done_bit;
   logic       nrdy_bit;
   ccs_sel_s   wr_sel;

   // Reserved source codes fall back to the fast internal oscillator
   function automatic logic [2:0] ccs_fix_src(input logic [2:0] s);
      if (s == CCS_SRC_RSV_HI || s == CCS_SRC_RSV_LO) begin
         return CCS_SRC_FAST;
      end
      return s;
   endfunction

   // Ready indication of the oscillator behind a source code
   function automatic logic ccs_src_ready(input logic [2:0] s, input ccs_rdy_s r);
      logic q;
      q = 1'b0;
      unique case (s)
         CCS_SRC_EXT:     q = r.external_ready;
         CCS_SRC_SLOW:    q = r.slow_internal_ready;
         CCS_SRC_SEC:     q = r.secondary_ready;
         CCS_SRC_EXT_X4:  q = r.multiplier_ready & r.external_ready;
         CCS_SRC_FAST_X2: q = r.multiplier_ready & r.fast_internal_ready;
         default:         q = r.fast_internal_ready;
      endcase
      return q;
   endfunction

   // Divider code to ratio; reserved codes never get stored
   function automatic logic [9:0] ccs_ratio(input logic [3:0] d);
      return 10'h001 << d;
   endfunction

   function automatic logic [31:0] ccs_pack_sel(input ccs_sel_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CCS_F_SRC_LO +: 3] = s.src;
      w[CCS_F_DIV_LO +: 4] = s.div;
      return w;
   endfunction

   // Bus side: zero-wait slave, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = rdata_reg;
   assign addr_phase = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         dp_wr_reg   <= addr_phase & hwrite;
         dp_addr_reg <= haddr;
      end
   end

   assign wr_req  = dp_wr_reg && dp_addr_reg == CCS_OFF_REQ;
   assign wr_ctrl = dp_wr_reg && dp_addr_reg == CCS_OFF_CTRL;

   always_comb begin
      wr_sel.src = ccs_fix_src(hwdata[CCS_F_SRC_LO +: 3]);
      wr_sel.div = hwdata[CCS_F_DIV_LO +: 4];
      // A reserved divider leaves the stored one in place
      if (wr_sel.div > CCS_DIV_MAX) begin
         wr_sel.div = req_reg.div;
      end
   end

   // Status bits seen by software
   assign done_bit = (req_reg == cur_reg) && state_reg == CCS_ST_IDLE;
   assign new_rdy  = ccs_src_ready(req_reg.src, osc_ready);
   assign nrdy_bit = state_reg != CCS_ST_IDLE && new_rdy;

   // Read data registered in the address phase, so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         rdata_reg <= 32'h0000_0000;
         unique case (haddr)
            CCS_OFF_REQ: rdata_reg <= ccs_pack_sel(req_reg);
            CCS_OFF_CUR: rdata_reg <= ccs_pack_sel(cur_reg);
            CCS_OFF_CTRL: begin
               rdata_reg[CCS_B_HOLD] <= hold_reg;
               rdata_reg[CCS_B_PWR]  <= pwr_reg;
               rdata_reg[CCS_B_BYP]  <= byp_reg;
               rdata_reg[CCS_B_DONE] <= done_bit;
               rdata_reg[CCS_B_NRDY] <= nrdy_bit;
            end
            CCS_OFF_STAT: begin
               rdata_reg[CCS_B_EXT]  <= osc_ready.external_ready;
               rdata_reg[CCS_B_FAST] <= osc_ready.fast_internal_ready;
               rdata_reg[CCS_B_SLOW] <= osc_ready.slow_internal_ready;
               rdata_reg[CCS_B_SEC]  <= osc_ready.secondary_ready;
               rdata_reg[CCS_B_FRC]  <= osc_ready.fixed_rc_ready;
               rdata_reg[CCS_B_MUL]  <= osc_ready.multiplier_ready;
            end
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Request register; strap caught on the first edge after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loaded_reg <= 1'b0;
         req_reg    <= CCS_SEL_RESET;
      end else if (!loaded_reg) begin
         loaded_reg <= 1'b1;
         req_reg.src <= ccs_fix_src(power_on_sel.src);
         req_reg.div <= (power_on_sel.div > CCS_DIV_MAX) ? CCS_DIV_RESET : power_on_sel.div;
      end else if (wr_req && switch_allow_config) begin
         req_reg <= wr_sel;
      end
   end

   // Control bits; writes to done and new-ready positions are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_reg <= 1'b0;
         byp_reg <= 1'b0;
      end else if (wr_ctrl) begin
         pwr_reg <= hwdata[CCS_B_PWR];
         byp_reg <= hwdata[CCS_B_BYP];
      end
   end

   // Hold bit: only a write changes it; a write is ignored in the held state while the bit is already clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_reg <= 1'b0;
      end else if (state_reg == CCS_ST_HELD && !hold_reg) begin
         hold_reg <= 1'b0;
      end else if (wr_ctrl) begin
         hold_reg <= hwdata[CCS_B_HOLD];
      end
   end

   // Switch sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= CCS_ST_IDLE;
         cur_reg   <= CCS_SEL_RESET;
         irq_reg   <= 1'b0;
      end else begin
         irq_reg <= 1'b0;
         if (!loaded_reg) begin
            cur_reg.src <= ccs_fix_src(power_on_sel.src);
            cur_reg.div <= (power_on_sel.div > CCS_DIV_MAX) ? CCS_DIV_RESET : power_on_sel.div;
         end else begin
            unique case (state_reg)
               CCS_ST_IDLE: begin
                  if (req_reg != cur_reg) begin
                     state_reg <= CCS_ST_SWITCH;
                  end
               end
               CCS_ST_SWITCH: begin
                  if (req_reg == cur_reg) begin
                     state_reg <= CCS_ST_IDLE;
                  end else if (new_rdy && hold_reg) begin
                     state_reg <= CCS_ST_HELD;
                     irq_reg   <= 1'b1;
                  end else if (new_rdy) begin
                     cur_reg   <= req_reg;
                     irq_reg   <= 1'b1;
                     state_reg <= CCS_ST_IDLE;
                  end
               end
               CCS_ST_HELD: begin
                  // Old clock kept until software drops the hold
                  if (req_reg == cur_reg) begin
                     state_reg <= CCS_ST_IDLE;
                  end else if (!new_rdy) begin
                     state_reg <= CCS_ST_SWITCH;
                  end else if (!hold_reg) begin
                     cur_reg   <= req_reg;
                     state_reg <= CCS_ST_IDLE;
                  end
               end
               default: state_reg <= CCS_ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ratio_reg <= 10'h001;
      end else begin
         ratio_reg <= ccs_ratio(cur_reg.div);
      end
   end

   assign current_sel          = cur_reg;
   assign requested_sel        = req_reg;
   assign divide_ratio         = ratio_reg;
   assign switch_irq_flag      = irq_reg;
   assign secondary_high_power = pwr_reg & ~byp_reg;
   assign secondary_bypass_en  = byp_reg;
   assign secondary_xtal_en    = ~byp_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_ready_seen;
      state_reg == CCS_ST_SWITCH && req_reg != cur_reg && new_rdy;
   endsequence

   property p_hold_pause;
      s_ready_seen and hold_reg |=> state_reg == CCS_ST_HELD && irq_reg && $stable(cur_reg);
   endproperty
   a_hold_pause: assert property (p_hold_pause) else $error("held switch not paused");

   property p_held_keeps_clock;
      state_reg == CCS_ST_HELD && hold_reg |=> $stable(cur_reg);
   endproperty
   a_held_keeps_clock: assert property (p_held_keeps_clock) else $error("clock moved in hold");

   property p_complete;
      s_ready_seen and !hold_reg |=> cur_reg == $past(req_reg) && irq_reg ##1 !irq_reg;
   endproperty
   a_complete: assert property (p_complete) else $error("switch did not complete");

   property p_power_ignored;
      byp_reg |-> !secondary_high_power && !secondary_xtal_en;
   endproperty
   a_power_ignored: assert property (p_power_ignored) else $error("bypass not honoured");

   property p_done_low;
      state_reg != CCS_ST_IDLE |-> !done_bit;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done set while switching");

   property p_new_ready;
      nrdy_bit |-> state_reg != CCS_ST_IDLE && ccs_src_ready(req_reg.src, osc_ready);
   endproperty
   a_new_ready: assert property (p_new_ready) else $error("new ready outside switch");

   property p_no_reserved;
      loaded_reg |-> req_reg.src != CCS_SRC_RSV_HI && req_reg.src != CCS_SRC_RSV_LO;
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved source stored");

   property p_locked;
      loaded_reg && !switch_allow_config |=> $stable(req_reg);
   endproperty
   a_locked: assert property (p_locked) else $error("locked request changed");

   property p_hold_release;
      state_reg == CCS_ST_HELD && !hold_reg && new_rdy && req_reg != cur_reg
         |=> state_reg == CCS_ST_IDLE && !hold_reg && cur_reg == $past(req_reg);
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("held switch stuck");

   property p_upper_zero;
      1'b1 |-> rdata_reg[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("unused read bits set");

   // Only the sequencer may move the current selection once the strap is in
   sequence s_cur_moved;
      loaded_reg && $past(loaded_reg) && $changed(cur_reg);
   endsequence

   sequence s_switch_wanted;
      loaded_reg && state_reg == CCS_ST_IDLE && req_reg != cur_reg;
   endsequence

   property p_cur_by_switch;
      s_cur_moved |-> $past(state_reg) != CCS_ST_IDLE && cur_reg == $past(req_reg);
   endproperty
   a_cur_by_switch: assert property (p_cur_by_switch) else $error("current moved alone");

   property p_switch_start;
      s_switch_wanted |=> state_reg == CCS_ST_SWITCH && !done_bit;
   endproperty
   a_switch_start: assert property (p_switch_start) else $error("switch not started");

   property p_irq_pulse;
      irq_reg |=> !irq_reg;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("flag pulse too long");

   property p_irq_cause;
      irq_reg |-> $past(state_reg) == CCS_ST_SWITCH && $past(new_rdy);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("flag without ready source");

   property p_done_match;
      done_bit |-> req_reg == cur_reg;
   endproperty
   a_done_match: assert property (p_done_match) else $error("done with mismatched selection");

   property p_div_legal;
      loaded_reg |-> req_reg.div <= CCS_DIV_MAX && cur_reg.div <= CCS_DIV_MAX;
   endproperty
   a_div_legal: assert property (p_div_legal) else $error("reserved divider stored");

   property p_ratio_onehot;
      1'b1 |-> $onehot(ratio_reg);
   endproperty
   a_ratio_onehot: assert property (p_ratio_onehot) else $error("ratio not a power of two");

   property p_cur_legal;
      loaded_reg |-> cur_reg.src != CCS_SRC_RSV_HI && cur_reg.src != CCS_SRC_RSV_LO;
   endproperty
   a_cur_legal: assert property (p_cur_legal) else $error("reserved current source");

   property p_xtal_mode;
      !byp_reg |-> secondary_xtal_en && secondary_high_power == pwr_reg;
   endproperty
   a_xtal_mode: assert property (p_xtal_mode) else $error("crystal mode pins wrong");
endmodule

/* logic/ccs_pkg.sv */
// Purpose: constants and types for the clock switch control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: strap and oscillator ready levels come from outside this block
package ccs_pkg;
   localparam logic [7:0] CCS_OFF_REQ  = 8'h00;
   localparam logic [7:0] CCS_OFF_CUR  = 8'h04;
   localparam logic [7:0] CCS_OFF_CTRL = 8'h08;
   localparam logic [7:0] CCS_OFF_STAT = 8'h0c;

   localparam logic [2:0] CCS_SRC_EXT     = 3'h7;
   localparam logic [2:0] CCS_SRC_FAST    = 3'h6;
   localparam logic [2:0] CCS_SRC_RSV_HI  = 3'h5;
   localparam logic [2:0] CCS_SRC_SLOW    = 3'h4;
   localparam logic [2:0] CCS_SRC_SEC     = 3'h3;
   localparam logic [2:0] CCS_SRC_RSV_LO  = 3'h2;
   localparam logic [2:0] CCS_SRC_EXT_X4  = 3'h1;
   localparam logic [2:0] CCS_SRC_FAST_X2 = 3'h0;

   localparam logic [3:0] CCS_DIV_MAX   = 4'h9;
   localparam logic [3:0] CCS_DIV_RESET = 4'h0;

   // Bit positions in the switch control register
   localparam int CCS_B_HOLD  = 7;
   localparam int CCS_B_PWR   = 6;
   localparam int CCS_B_BYP   = 5;
   localparam int CCS_B_DONE  = 4;
   localparam int CCS_B_NRDY  = 3;
   // Field positions in request/current registers
   localparam int CCS_F_SRC_LO = 4;
   localparam int CCS_F_DIV_LO = 0;
   // Bit positions in the ready status register
   localparam int CCS_B_EXT  = 7;
   localparam int CCS_B_FAST = 6;
   localparam int CCS_B_SLOW = 4;
   localparam int CCS_B_SEC  = 3;
   localparam int CCS_B_FRC  = 2;
   localparam int CCS_B_MUL  = 0;

   typedef struct packed {
      logic [2:0] src;
      logic [3:0] div;
   } ccs_sel_s;

   localparam ccs_sel_s CCS_SEL_RESET = '{src: CCS_SRC_FAST, div: CCS_DIV_RESET};

   typedef struct packed {
      logic external_ready;
      logic fast_internal_ready;
      logic slow_internal_ready;
      logic secondary_ready;
      logic fixed_rc_ready;
      logic multiplier_ready;
   } ccs_rdy_s;

   typedef enum logic [1:0] {
      CCS_ST_IDLE   = 2'b00,
      CCS_ST_SWITCH = 2'b01,
      CCS_ST_HELD   = 2'b10
   } ccs_state_e;
endpackage

/* test/ccs_clock_switch_tb.sv */
// Purpose: self-checking bench for the clock switch control block
// Assumes: zero-wait register slave; oscillator ready levels driven here
// Notes: one task per scenario; registers reached over AHB-Lite
`timescale 1ns/10ps
module ccs_clock_switch_tb;
   import ccs_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        cfg;
   ccs_sel_s    pon;
   ccs_rdy_s    rdy;
   ccs_sel_s    cur;
   ccs_sel_s    req;
   logic [9:0]  ratio;
   logic        irq;
   logic        hp;
   logic        byp;
   logic        xtal;
   logic [31:0] rd;
   int          n;
   int          error_cnt = 0;
   int          comparisons = 0;

   ccs_clock_switch u_ccs_clock_switch (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .switch_allow_config(cfg), .power_on_sel(pon), .osc_ready(rdy),
      .current_sel(cur), .requested_sel(req), .divide_ratio(ratio),
      .switch_irq_flag(irq), .secondary_high_power(hp),
      .secondary_bypass_en(byp), .secondary_xtal_en(xtal));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Called at a rising edge; address phase held until hready seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // Observation window counting switch pulses
   task automatic span(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(posedge hclk);
         if (irq === 1'b1)
            n++;
      end
   endtask

   task automatic do_reset(input logic c, input logic [6:0] p);
      hresetn <= 1'b0;
      cfg     <= c;
      pon     <= p;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask

   task automatic t_reset();
      rchk("ctrl", CCS_OFF_CTRL, 32'h10);
      rchk("cur", CCS_OFF_CUR, 32'h60);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      bus(1'b1, CCS_OFF_STAT, 32'h0);
      bus(1'b1, CCS_OFF_CUR, 32'h0);
      rchk("cur ro", CCS_OFF_CUR, 32'h60);
      rchk("unmapped", 8'h10, 32'h0);
      rdy <= 6'b101101;
      rchk("stat a", CCS_OFF_STAT, 32'h99);
      rdy <= 6'b010010;
      rchk("stat b", CCS_OFF_STAT, 32'h44);
      rdy <= 6'h3f;
      rchk("stat c", CCS_OFF_STAT, 32'hdd);
   endtask

   task automatic t_switch();
      logic [2:0] s;
      logic [2:0] srcs [6] = '{3'h7, 3'h4, 3'h3, 3'h1, 3'h0, 3'h6};
      for (int i = 0; i < 10; i++) begin
         s = srcs[i % 6];
         bus(1'b1, CCS_OFF_REQ, {25'h0, s, i[3:0]});
         span(8);
         chk("irq count", 32'd1, n);
         chk("cur src", {29'h0, s}, {29'h0, cur.src});
         chk("ratio", 32'd1 << i, {22'h0, ratio});
         rchk("cur reg", CCS_OFF_CUR, {25'h0, s, i[3:0]});
      end
      // Reserved source codes fall back to the fast internal source
      bus(1'b1, CCS_OFF_REQ, 32'h53);
      rchk("rsv hi", CCS_OFF_REQ, 32'h63);
      span(8);
      chk("rsv cur", 32'h6, {29'h0, cur.src});
      bus(1'b1, CCS_OFF_REQ, 32'h27);
      rchk("rsv lo", CCS_OFF_REQ, 32'h67);
      span(8);
      chk("rsv lo cur", 32'h67, {25'h0, cur});
      // Reserved divider keeps the stored one, so no switch follows
      bus(1'b1, CCS_OFF_REQ, 32'h6c);
      rchk("rsv div", CCS_OFF_REQ, 32'h67);
      span(8);
      chk("rsv div irq", 32'd0, n);
   endtask

   task automatic t_hold();
      rdy <= 6'b110111;
      bus(1'b1, CCS_OFF_CTRL, 32'h80);
      bus(1'b1, CCS_OFF_REQ, 32'h41);
      span(4);
      rchk("ctrl wait", CCS_OFF_CTRL, 32'h80);
      rdy <= 6'h3f;
      span(8);
      chk("held irq", 32'd1, n);
      chk("held cur", 32'h67, {25'h0, cur});
      rchk("ctrl held", CCS_OFF_CTRL, 32'h88);
      bus(1'b1, CCS_OFF_CTRL, 32'h07);
      span(8);
      chk("no 2nd irq", 32'd0, n);
      chk("released cur", 32'h41, {25'h0, cur});
      rchk("ctrl done", CCS_OFF_CTRL, 32'h10);
   endtask

   task automatic t_secondary();
      logic [7:0] codes [4] = '{8'h40, 8'h60, 8'h20, 8'h00};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, CCS_OFF_CTRL, {24'h0, codes[i]});
         @(posedge hclk);
         chk("high power", {31'h0, codes[i][6] & ~codes[i][5]}, {31'h0, hp});
         chk("bypass", {31'h0, codes[i][5]}, {31'h0, byp});
         chk("xtal", {31'h0, ~codes[i][5]}, {31'h0, xtal});
         rchk("ctrl sec", CCS_OFF_CTRL, {24'h0, codes[i][7:5], 5'h10});
      end
   endtask

   task automatic t_locked();
      do_reset(1'b0, 7'h32);
      rchk("req pon", CCS_OFF_REQ, 32'h32);
      bus(1'b1, CCS_OFF_REQ, 32'h75);
      rchk("req locked", CCS_OFF_REQ, 32'h32);
      chk("cur locked", 32'h32, {25'h0, cur});
      chk("req port", 32'h32, {25'h0, req});
   endtask

   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} <= '0;
      hsize <= 3'h2;
      rdy   <= 6'h3f;
      do_reset(1'b1, 7'h60);
      t_reset();
      t_switch();
      t_hold();
      t_secondary();
      t_locked();
      conclude();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      conclude();
   end
endmodule
